// ==== common/hws_pkg.sv ====
package hws_pkg;
	// ****************************************************************
	// Report layout
	// ****************************************************************
	localparam logic [7:0] HWS_OFF_ALERT_FLAGS = 8'h00;
	localparam logic [7:0] HWS_OFF_TEMP_LO = 8'h01;
	localparam logic [7:0] HWS_OFF_TEMP_HI = 8'h02;
	localparam int HWS_BIT_SPARE = 0;
	localparam int HWS_BIT_TEMP = 1;
	localparam int HWS_BIT_RELIAB = 2;
	localparam int HWS_BIT_READONLY = 3;
	localparam int HWS_BIT_BACKUP = 4;
	localparam int HWS_NUM_WARN = 5;
	localparam logic [7:0] HWS_FLAGS_RESET = 8'h00;
	localparam logic [15:0] HWS_TEMP_RESET = 16'h0000;
	localparam logic [7:0] HWS_BYTE_ZERO = 8'h00;
	localparam logic [7:0] HWS_SPARE_THRESH_RESET = 8'h0A;
	localparam logic [15:0] HWS_OVER_THRESH_RESET = 16'h0163;
	localparam logic [15:0] HWS_UNDER_THRESH_RESET = 16'h0111;
	localparam logic [1:0] HWS_CFG_SPARE = 2'h0;
	localparam logic [1:0] HWS_CFG_OVER = 2'h1;
	localparam logic [1:0] HWS_CFG_UNDER = 2'h2;
	// ****************************************************************
	// Event path
	// ****************************************************************
	typedef enum logic [1:0] {
		HWS_EV_IDLE = 2'h1,
		HWS_EV_SEND = 2'h2
	} hws_ev_state_t;
endpackage

// ==== src/hws_temp_cmp.sv ====
`timescale 1ns/1ps
module hws_temp_cmp
	import hws_pkg::*;
(
	input wire logic [15:0] temp,
	input wire logic [15:0] over_thresh,
	input wire logic [15:0] under_thresh,
	output logic out_of_range
);
	// Strict comparisons: a reading equal to a threshold is still in range.
	always_comb begin
		out_of_range = (temp > over_thresh) || (temp < under_thresh);
	end
endmodule

// ==== src/hws_event_gen.sv ====
`timescale 1ns/1ps
module hws_event_gen
	import hws_pkg::*;
#(
	parameter int NUM_WARN = HWS_NUM_WARN
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [NUM_WARN-1:0] warn,
	input wire logic [NUM_WARN-1:0] event_mask,
	output logic event_pulse,
	output logic [NUM_WARN-1:0] event_cause
);
	logic [NUM_WARN-1:0] warn_q;
	logic [NUM_WARN-1:0] next_warn_q;
	logic [NUM_WARN-1:0] next_cause;
	logic next_pulse;

	// Only rising edges notify; a warning that stays set never repeats.
	always_comb begin
		next_warn_q = warn;
		next_cause = warn & ~warn_q & event_mask;
		next_pulse = |next_cause;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			warn_q <= '0;
			event_cause <= '0;
			event_pulse <= 1'b0;
		end else if (enable) begin
			warn_q <= next_warn_q;
			event_cause <= next_cause;
			event_pulse <= next_pulse;
		end
	end
endmodule

// ==== src/hws_health_status.sv ====
`timescale 1ns/1ps
// Behaviour
// - Each bitmap bit is its own warning; any combination may be set together.
// - A zero bit means that warning condition is absent.
// - Bit 0 is set while spare capacity is below its threshold.
// - Bit 1 is set while temperature is over or under its thresholds.
// - Bit 2 is set while reliability is degraded by media or internal errors.
// - Bit 3 is set while media is in read-only condition.
// - Bit 4 is set when backup hardware failed, only if backup exists.
// - Bits follow the present condition and are never latched.
// - A rising warning bit may raise an event notice to the host.
// - Composite temperature is a 16-bit Kelvin value in report bytes 2:1.
// - Temperature derivation is implementation choice; here it is the supplied sensor value.
// - Composite temperature against thresholds can trigger the event notice.
module hws_health_status
	import hws_pkg::*;
#(
	parameter bit HAS_BACKUP = 1'b1
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [7:0] spare_percent,
	input wire logic [15:0] sensor_temp,
	input wire logic reliability_degraded,
	input wire logic media_read_only,
	input wire logic backup_failed,
	input wire logic cfg_write,
	input wire logic [1:0] cfg_sel,
	input wire logic [15:0] cfg_data,
	input wire logic [HWS_NUM_WARN-1:0] event_mask,
	input wire logic rd_en,
	input wire logic [7:0] rd_offset,
	input wire logic wr_en,
	input wire logic [7:0] wr_offset,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [7:0] health_alert_flags,
	output logic [15:0] composite_temp_kelvin,
	output logic event_pulse,
	output logic [HWS_NUM_WARN-1:0] event_cause
);
	// ****************************************************************
	// Threshold configuration
	// ****************************************************************
	logic [7:0] spare_thresh;
	logic [15:0] over_thresh;
	logic [15:0] under_thresh;
	logic [7:0] next_spare_thresh;
	logic [15:0] next_over_thresh;
	logic [15:0] next_under_thresh;

	always_comb begin
		next_spare_thresh = spare_thresh;
		next_over_thresh = over_thresh;
		next_under_thresh = under_thresh;
		if (cfg_write) begin
			case (cfg_sel)
				HWS_CFG_SPARE: begin
					next_spare_thresh = cfg_data[7:0];
				end
				HWS_CFG_OVER: begin
					next_over_thresh = cfg_data;
				end
				HWS_CFG_UNDER: begin
					next_under_thresh = cfg_data;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			spare_thresh <= HWS_SPARE_THRESH_RESET;
			over_thresh <= HWS_OVER_THRESH_RESET;
			under_thresh <= HWS_UNDER_THRESH_RESET;
		end else if (enable) begin
			spare_thresh <= next_spare_thresh;
			over_thresh <= next_over_thresh;
			under_thresh <= next_under_thresh;
		end
	end

	// ****************************************************************
	// Warning bitmap and temperature
	// ****************************************************************
	logic temp_bad;
	logic [7:0] next_flags;
	logic [15:0] next_temp;

	hws_temp_cmp u_cmp (
		.temp(sensor_temp),
		.over_thresh(over_thresh),
		.under_thresh(under_thresh),
		.out_of_range(temp_bad)
	);

	// The bitmap is recomputed every cycle from live inputs, so nothing sticks.
	always_comb begin
		next_flags = HWS_FLAGS_RESET;
		next_flags[HWS_BIT_SPARE] = spare_percent < spare_thresh;
		next_flags[HWS_BIT_TEMP] = temp_bad;
		next_flags[HWS_BIT_RELIAB] = reliability_degraded;
		next_flags[HWS_BIT_READONLY] = media_read_only;
		next_flags[HWS_BIT_BACKUP] = HAS_BACKUP && backup_failed;
		next_temp = sensor_temp;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			health_alert_flags <= HWS_FLAGS_RESET;
			composite_temp_kelvin <= HWS_TEMP_RESET;
		end else if (enable) begin
			health_alert_flags <= next_flags;
			composite_temp_kelvin <= next_temp;
		end
	end

	// ****************************************************************
	// Event notice
	// ****************************************************************
	hws_event_gen #(
		.NUM_WARN(HWS_NUM_WARN)
	) u_evt (
		.clock(clock),
		.reset_n(reset_n),
		.enable(enable),
		.warn(health_alert_flags[HWS_NUM_WARN-1:0]),
		.event_mask(event_mask),
		.event_pulse(event_pulse),
		.event_cause(event_cause)
	);

	// ****************************************************************
	// Report read port
	// ****************************************************************
	logic [7:0] next_rd_data;
	logic next_rd_valid;

	// Writes are accepted on the port but deliberately go nowhere.
	always_comb begin
		next_rd_valid = rd_en;
		next_rd_data = rd_data;
		if (rd_en) begin
			case (rd_offset)
				HWS_OFF_ALERT_FLAGS: begin
					next_rd_data = health_alert_flags;
				end
				HWS_OFF_TEMP_LO: begin
					next_rd_data = composite_temp_kelvin[7:0];
				end
				HWS_OFF_TEMP_HI: begin
					next_rd_data = composite_temp_kelvin[15:8];
				end
				default: begin
					next_rd_data = HWS_BYTE_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= HWS_BYTE_ZERO;
			rd_valid <= 1'b0;
		end else if (enable) begin
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_reserved_zero;
		@(posedge clock) disable iff (!reset_n) health_alert_flags[7:5] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_spare;
		@(posedge clock) disable iff (!reset_n)
		enable |=> health_alert_flags[HWS_BIT_SPARE] == ($past(spare_percent) < $past(spare_thresh));
	endproperty
	a_spare: assert property (p_spare) else $error("spare bit wrong");

	property p_temp;
		@(posedge clock) disable iff (!reset_n)
		enable |=> health_alert_flags[HWS_BIT_TEMP] ==
			(($past(sensor_temp) > $past(over_thresh)) || ($past(sensor_temp) < $past(under_thresh)));
	endproperty
	a_temp: assert property (p_temp) else $error("temperature bit wrong");

	property p_reliab;
		@(posedge clock) disable iff (!reset_n)
		enable |=> health_alert_flags[HWS_BIT_RELIAB] == $past(reliability_degraded);
	endproperty
	a_reliab: assert property (p_reliab) else $error("reliability bit wrong");

	property p_ro;
		@(posedge clock) disable iff (!reset_n)
		enable && !media_read_only |=> !health_alert_flags[HWS_BIT_READONLY];
	endproperty
	a_ro: assert property (p_ro) else $error("read-only bit latched");

	property p_backup;
		@(posedge clock) disable iff (!reset_n)
		enable |=> health_alert_flags[HWS_BIT_BACKUP] == (HAS_BACKUP && $past(backup_failed));
	endproperty
	a_backup: assert property (p_backup) else $error("backup bit wrong");

	property p_temp_value;
		@(posedge clock) disable iff (!reset_n)
		enable |=> composite_temp_kelvin == $past(sensor_temp);
	endproperty
	a_temp_value: assert property (p_temp_value) else $error("temperature value wrong");

	property p_event;
		@(posedge clock) disable iff (!reset_n)
		enable && $rose(health_alert_flags[HWS_BIT_TEMP]) && event_mask[HWS_BIT_TEMP] |=> event_pulse;
	endproperty
	a_event: assert property (p_event) else $error("missing event notice");

	property p_read_flags;
		@(posedge clock) disable iff (!reset_n)
		enable && rd_en && rd_offset == HWS_OFF_ALERT_FLAGS |=> rd_valid && rd_data == $past(health_alert_flags);
	endproperty
	a_read_flags: assert property (p_read_flags) else $error("bitmap readback wrong");

	property p_write_ignored;
		@(posedge clock) disable iff (!reset_n)
		enable && wr_en && $past(enable) && $past(reset_n)
			&& $stable(sensor_temp) && $stable(spare_percent) && $stable(reliability_degraded)
			&& $stable(media_read_only) && $stable(backup_failed)
			&& $stable(spare_thresh) && $stable(over_thresh) && $stable(under_thresh)
		|=> health_alert_flags == $past(health_alert_flags)
			&& composite_temp_kelvin == $past(composite_temp_kelvin);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write changed a field");

	// ****************************************************************
	// Read port and event checks
	// ****************************************************************

	// A frozen block must hold the answers it already gave, not only the report.
	property p_freeze;
		@(posedge clock) disable iff (!reset_n)
		!enable |=> $stable(health_alert_flags) && $stable(composite_temp_kelvin) && $stable(event_pulse)
			&& $stable(rd_valid) && $stable(rd_data);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while enable low");

	property p_read_valid;
		@(posedge clock) disable iff (!reset_n)
		enable |=> rd_valid == $past(rd_en);
	endproperty
	a_read_valid: assert property (p_read_valid) else $error("read valid not a one-cycle answer");

	property p_read_temp_lo;
		@(posedge clock) disable iff (!reset_n)
		enable && rd_en && rd_offset == HWS_OFF_TEMP_LO
		|=> {8'h00, rd_data} == ($past(composite_temp_kelvin) & 16'h00FF);
	endproperty
	a_read_temp_lo: assert property (p_read_temp_lo) else $error("temperature low byte wrong");

	property p_read_temp_hi;
		@(posedge clock) disable iff (!reset_n)
		enable && rd_en && rd_offset == HWS_OFF_TEMP_HI
		|=> {rd_data, 8'h00} == ($past(composite_temp_kelvin) & 16'hFF00);
	endproperty
	a_read_temp_hi: assert property (p_read_temp_hi) else $error("temperature high byte wrong");

	property p_read_unmapped;
		@(posedge clock) disable iff (!reset_n)
		enable && rd_en && rd_offset > HWS_OFF_TEMP_HI |=> rd_data == HWS_BYTE_ZERO;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped offset not zero");

	property p_pulse_cause;
		@(posedge clock) disable iff (!reset_n)
		event_pulse == (event_cause != '0);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("event pulse and cause disagree");

	property p_cause_masked;
		@(posedge clock) disable iff (!reset_n)
		$past(enable) |-> (event_cause & ~$past(event_mask)) == '0;
	endproperty
	a_cause_masked: assert property (p_cause_masked) else $error("masked warning raised an event");

	property p_cause_set;
		@(posedge clock) disable iff (!reset_n)
		$past(enable) |-> (8'(event_cause) & ~$past(health_alert_flags)) == 8'h00;
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("event cause without warning");

	property p_cause_new;
		@(posedge clock) disable iff (!reset_n)
		$past(enable) && $past(enable, 2) |-> (8'(event_cause) & $past(health_alert_flags, 2)) == 8'h00;
	endproperty
	a_cause_new: assert property (p_cause_new) else $error("event repeated for a standing warning");

	c_event: cover property (@(posedge clock) disable iff (!reset_n) event_pulse);
	c_multi: cover property (@(posedge clock) disable iff (!reset_n) $countones(health_alert_flags) > 1);
	c_read_temp: cover property (@(posedge clock) disable iff (!reset_n) rd_en && rd_offset == HWS_OFF_TEMP_HI);
	c_freeze: cover property (@(posedge clock) disable iff (!reset_n) !enable && media_read_only);
	c_masked: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(health_alert_flags[HWS_BIT_SPARE]) && !event_mask[HWS_BIT_SPARE]);
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb
	import hws_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic enable = 1'b1;
	logic [7:0] spare_percent = 8'h50;
	logic [15:0] sensor_temp = 16'h0130;
	logic reliability_degraded = 1'b0;
	logic media_read_only = 1'b0;
	logic backup_failed = 1'b0;
	logic cfg_write = 1'b0;
	logic [1:0] cfg_sel = 2'h0;
	logic [15:0] cfg_data = 16'h0000;
	logic [HWS_NUM_WARN-1:0] event_mask = 5'h1F;
	logic rd_en = 1'b0;
	logic [7:0] rd_offset = 8'h00;
	logic wr_en = 1'b0;
	logic [7:0] wr_offset = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic rd_valid;
	logic [7:0] health_alert_flags;
	logic [15:0] composite_temp_kelvin;
	logic event_pulse;
	logic [HWS_NUM_WARN-1:0] event_cause;
	int miscompares = 0;
	int samples_checked = 0;

	hws_health_status #(.HAS_BACKUP(1'b1)) i_dut (.clock(clock), .reset_n(reset_n), .enable(enable),
		.spare_percent(spare_percent), .sensor_temp(sensor_temp), .reliability_degraded(reliability_degraded),
		.media_read_only(media_read_only), .backup_failed(backup_failed), .cfg_write(cfg_write),
		.cfg_sel(cfg_sel), .cfg_data(cfg_data), .event_mask(event_mask), .rd_en(rd_en), .rd_offset(rd_offset),
		.wr_en(wr_en), .wr_offset(wr_offset), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
		.health_alert_flags(health_alert_flags), .composite_temp_kelvin(composite_temp_kelvin),
		.event_pulse(event_pulse), .event_cause(event_cause));

	always #5 clock = ~clock;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Called right at a rising edge so the change lands off the sampling point.
	task automatic set_cond(input int i, input logic v);
		case (i)
			0: spare_percent <= v ? 8'h05 : 8'h50;
			1: sensor_temp <= v ? 16'h0170 : 16'h0130;
			2: reliability_degraded <= v;
			3: media_read_only <= v;
			default: backup_failed <= v;
		endcase
	endtask

	task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_offset <= off;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk(rd_valid, 1'b1, "rd_valid");
		chk(rd_data, exp, "rd_data");
		settle(1);
		chk({rd_valid, rd_data}, {1'b0, exp}, "rd_data held");
	endtask

	task automatic cfg_wr(input logic [1:0] sel, input logic [15:0] data);
		@(posedge clock);
		cfg_write <= 1'b1;
		cfg_sel <= sel;
		cfg_data <= data;
		@(posedge clock);
		cfg_write <= 1'b0;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_single_bits();
		for (int i = 0; i < HWS_NUM_WARN; i++) begin
			@(posedge clock);
			set_cond(i, 1'b1);
			settle(1);
			chk(health_alert_flags, 8'h01 << i, "single flag");
			settle(1);
			chk({event_pulse, 3'h0, event_cause}, {1'b1, 3'h0, 5'h01 << i}, "event on rise");
			settle(1);
			chk(event_pulse, 1'b0, "event one cycle");
			@(posedge clock);
			set_cond(i, 1'b0);
			settle(1);
			chk(health_alert_flags, HWS_FLAGS_RESET, "flag drops");
		end
		$display("test_single_bits done");
	endtask

	task automatic test_all_bits();
		@(posedge clock);
		for (int i = 0; i < HWS_NUM_WARN; i++) set_cond(i, 1'b1);
		settle(1);
		chk(health_alert_flags, 8'h1F, "all flags, reserved zero");
		settle(1);
		chk(event_cause, 5'h1F, "all causes");
		@(posedge clock);
		for (int i = 0; i < HWS_NUM_WARN; i++) set_cond(i, 1'b0);
		settle(1);
		chk(health_alert_flags, HWS_FLAGS_RESET, "all clear");
		$display("test_all_bits done");
	endtask

	task automatic test_temp_edges();
		logic [15:0] temps [4] = '{16'h0163, 16'h0164, 16'h0111, 16'h0110};
		logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h00, 8'h02};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			sensor_temp <= temps[i];
			settle(1);
			chk(composite_temp_kelvin, temps[i], "temperature");
			chk(health_alert_flags, exp[i], "temp threshold");
		end
		@(posedge clock);
		sensor_temp <= 16'h0130;
		$display("test_temp_edges done");
	endtask

	// Host writes must leave the report untouched; an unmapped offset reads zero.
	task automatic test_read_port();
		@(posedge clock);
		sensor_temp <= 16'h015C;
		media_read_only <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b1;
		wr_offset <= HWS_OFF_ALERT_FLAGS;
		wr_data <= 8'hFF;
		@(posedge clock);
		wr_offset <= HWS_OFF_TEMP_LO;
		wr_data <= 8'h00;
		@(posedge clock);
		wr_en <= 1'b0;
		rd_chk(HWS_OFF_ALERT_FLAGS, 8'h08);
		rd_chk(HWS_OFF_TEMP_LO, 8'h5C);
		rd_chk(HWS_OFF_TEMP_HI, 8'h01);
		rd_chk(8'h03, HWS_BYTE_ZERO);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_offset <= HWS_OFF_TEMP_LO;
		@(posedge clock);
		rd_offset <= HWS_OFF_TEMP_HI;
		#1;
		chk(rd_data, 8'h5C, "first back-to-back read");
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk({rd_valid, rd_data}, {1'b1, 8'h01}, "second back-to-back read");
		@(posedge clock);
		media_read_only <= 1'b0;
		sensor_temp <= 16'h0130;
		settle(2);
		$display("test_read_port done");
	endtask

	task automatic test_cfg_mask();
		@(posedge clock);
		event_mask <= 5'h00;
		cfg_wr(HWS_CFG_SPARE, 16'h0060);
		settle(1);
		chk(health_alert_flags, 8'h01, "raised spare threshold");
		settle(1);
		chk(event_pulse, 1'b0, "masked event");
		cfg_wr(HWS_CFG_SPARE, 16'h000A);
		event_mask <= 5'h1F;
		settle(2);
		chk(health_alert_flags, HWS_FLAGS_RESET, "threshold restored");
		$display("test_cfg_mask done");
	endtask

	task automatic test_cfg_temp();
		cfg_wr(HWS_CFG_OVER, 16'h0120);
		settle(1);
		chk(health_alert_flags, 8'h02, "over threshold lowered");
		settle(1);
		chk({event_pulse, event_cause}, 6'h22, "event from temperature");
		cfg_wr(HWS_CFG_OVER, HWS_OVER_THRESH_RESET);
		cfg_wr(HWS_CFG_UNDER, 16'h0140);
		settle(1);
		chk(health_alert_flags, 8'h02, "under threshold raised");
		cfg_wr(HWS_CFG_UNDER, HWS_UNDER_THRESH_RESET);
		cfg_wr(2'h3, 16'h0000);
		settle(1);
		chk(health_alert_flags, HWS_FLAGS_RESET, "unused selector ignored");
		$display("test_cfg_temp done");
	endtask

	// A condition that appears while enable is low must wait for enable.
	task automatic test_enable_freeze();
		@(posedge clock);
		enable <= 1'b0;
		media_read_only <= 1'b1;
		settle(2);
		chk(health_alert_flags, HWS_FLAGS_RESET, "frozen flags");
		@(posedge clock);
		enable <= 1'b1;
		settle(1);
		chk(health_alert_flags, 8'h08, "flags after enable");
		settle(1);
		chk({event_pulse, event_cause}, 6'h28, "event after enable");
		@(posedge clock);
		media_read_only <= 1'b0;
		settle(1);
		chk(health_alert_flags, HWS_FLAGS_RESET, "flag drops after freeze");
		$display("test_enable_freeze done");
	endtask

	// A reset in mid-run must bring the thresholds back as well as the outputs.
	task automatic test_mid_reset();
		cfg_wr(HWS_CFG_SPARE, 16'h0060);
		settle(1);
		chk(health_alert_flags, 8'h01, "spare flag before reset");
		@(posedge clock);
		reset_n <= 1'b0;
		settle(2);
		chk({event_pulse, health_alert_flags}, 9'h000, "outputs in mid-run reset");
		@(posedge clock);
		reset_n <= 1'b1;
		settle(2);
		chk(health_alert_flags, HWS_FLAGS_RESET, "threshold back to reset value");
		$display("test_mid_reset done");
	endtask

	// ****************************************************************
	// Run control
	// ****************************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// The whole run is about 130 cycles, so this limit only trips on a hang.
	initial begin
		#20000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		settle(20);
		chk(health_alert_flags, HWS_FLAGS_RESET, "flags in reset");
		chk(composite_temp_kelvin, HWS_TEMP_RESET, "temp in reset");
		chk({rd_valid, event_pulse}, 2'h0, "pulses in reset");
		@(posedge clock);
		reset_n <= 1'b1;
		settle(3);
		test_single_bits();
		test_all_bits();
		test_temp_edges();
		test_read_port();
		test_cfg_mask();
		test_cfg_temp();
		test_enable_freeze();
		test_mid_reset();
		report_and_stop();
	end
endmodule
